// >>> hdl/lcr_defs.vh
// Offsets, field positions, reset values and constants of the configuration block
`ifndef LCR_DEFS_VH
`define LCR_DEFS_VH
// ------------------------------------------------------------
// Register byte offsets on the software bus
// ------------------------------------------------------------
`define LCR_OFS_A 4'h0
`define LCR_OFS_B 4'h4
`define LCR_OFS_C 4'h8
`define LCR_OFS_RING 4'hc
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LCR_RST_A 8'h01
`define LCR_RST_B 8'h01
`define LCR_RST_C 8'h20
`define LCR_RST_RING_START 8'h46
`define LCR_RST_RING_STOP 8'h80
// ------------------------------------------------------------
// Field positions, first register
// ------------------------------------------------------------
`define LCR_A_IOB_HI 2
`define LCR_A_IOB_LO 0
`define LCR_A_IRQ_HI 5
`define LCR_A_IRQ_LO 3
`define LCR_A_FAST_REMOTE_READ_EN 6
`define LCR_A_MODE 7
// ------------------------------------------------------------
// Field positions, second register
// ------------------------------------------------------------
`define LCR_B_MED_HI 1
`define LCR_B_MED_LO 0
`define LCR_B_LINK 2
`define LCR_B_IO16 3
`define LCR_B_RDY 4
`define LCR_B_BERR 5
`define LCR_B_BOOT_ROM_WRITE_ALLOW 6
`define LCR_B_EEST 7
// ------------------------------------------------------------
// Field positions, third register
// ------------------------------------------------------------
`define LCR_C_BPS_HI 3
`define LCR_C_BPS_LO 0
`define LCR_C_DEPTH 4
`define LCR_C_IMODE 5
`define LCR_C_CLKS 6
`define LCR_C_LOCK 7
// ------------------------------------------------------------
// Codes and host I/O constants
// ------------------------------------------------------------
`define LCR_IOB_SOFT 3'h1
`define LCR_MED_THIN 2'h1
`define LCR_SW_PORT 10'h278
`define LCR_SW_WRITES 3'h4
`define LCR_IO_ROOT 10'h200
`define LCR_IO_STEP 10'h020
`endif

// >>> hdl/lcr_sw_load.v
// Software-mode watcher that loads the first register from port writes
`timescale 1ns/100ps
module lcr_sw_load
(
  input wire mclk,
  input wire resetn,
  input wire armed,
  input wire wr_pulse,
  input wire [9:0] wr_addr,
  input wire [7:0] wr_data,
  output reg load_pulse,
  output reg [7:0] load_data
);
`include "lcr_defs.vh"
  // Count of back-to-back writes to the watched port
  reg [2:0] hits;
  wire [2:0] next_hits;

  assign next_hits = hits + 3'h1;

  // ------------------------------------------------------------
  // Counter: any write elsewhere breaks the run
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      hits <= 3'h0;
      load_pulse <= 1'b0;
      load_data <= 8'h00;
    end
    else
    begin
      load_pulse <= 1'b0;
      if (!armed)
        hits <= 3'h0;
      else if (wr_pulse)
      begin
        if (wr_addr != `LCR_SW_PORT)
          hits <= 3'h0;
        else if (next_hits == `LCR_SW_WRITES)
        begin
          // Fourth write carries the new register value
          hits <= 3'h0;
          load_pulse <= 1'b1;
          load_data <= wr_data;
        end
        else
          hits <= next_hits;
      end
    end
  end
endmodule

// >>> hdl/lcr_ram_arb.v
// Arbiter for the local buffer RAM bus between network core and host
`timescale 1ns/100ps
module lcr_ram_arb
(
  input wire mclk,
  input wire resetn,
  input wire core_req,
  input wire host_req,
  output reg core_grant,
  output reg host_grant
);
  // ------------------------------------------------------------
  // Grant holds while its owner requests; core wins a tie
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      core_grant <= 1'b0;
      host_grant <= 1'b0;
    end
    else if (core_grant && core_req)
    begin
      core_grant <= 1'b1;
      host_grant <= 1'b0;
    end
    else if (host_grant && host_req)
    begin
      // No preemption of a running host access
      core_grant <= 1'b0;
      host_grant <= 1'b1;
    end
    else
    begin
      // Idle or released: core first, keeps its latency short
      core_grant <= core_req;
      host_grant <= host_req && !core_req;
    end
  end
endmodule

// >>> hdl/lcr_config_regs.v
// Configuration register bank, host I/O signalling and buffer RAM ownership
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
module lcr_config_regs
(
  input wire mclk,
  input wire resetn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [9:0] isa_sa,
  input wire [7:0] isa_sd,
  input wire isa_iow_n,
  input wire isa_ior_n,
  input wire isa_bale,
  output reg io16_n,
  output reg iochrdy_out,
  output reg iochrdy_oe_n,
  input wire core_not_ready,
  input wire link_good,
  input wire core_irq,
  output reg [7:0] irq_direct,
  output reg [2:0] irq_code,
  output reg irq_strobe_out,
  output reg fast_remote_read_en,
  output reg host_bus_mode_sel,
  output reg thin_enable,
  output reg [1:0] medium_select,
  output reg link_test_disable,
  output reg boot_rom_enable,
  output reg [3:0] boot_rom_window_sel,
  output reg boot_rom_write_allow,
  output reg eeprom_store_enable,
  output reg ram_full_depth,
  output reg core_clock_source_sel,
  input wire core_dma_burst,
  input wire host_mem_req,
  input wire host_latch_req,
  input wire [15:0] host_ram_addr,
  output reg [15:0] ram_host_addr,
  output reg core_ram_grant,
  output reg host_ram_grant,
  input wire rx_page_done,
  output reg [7:0] rx_ring_page,
  output reg rx_ring_full
);
`include "lcr_defs.vh"
  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  reg [7:0] cfg_a; // config_base_irq_mode
  reg [7:0] cfg_b; // config_media_bus_options, bit 5 unused here
  reg [7:0] cfg_c; // config_boot_mem_clock
  reg bus_error_flag; // Sticky, cleared by reading the second register
  reg [7:0] ring_start; // First receive page
  reg [7:0] ring_stop; // Page past the last one
  reg [7:0] ring_bound; // Page software reads next
  // Field views
  wire [2:0] io_base_select;
  wire [2:0] irq_line_select;
  wire irq_encoding_sel;
  wire sw_config_lockout;
  wire soft_mode;
  wire shared_mode;
  assign io_base_select = cfg_a[`LCR_A_IOB_HI:`LCR_A_IOB_LO];
  assign irq_line_select = cfg_a[`LCR_A_IRQ_HI:`LCR_A_IRQ_LO];
  assign irq_encoding_sel = cfg_c[`LCR_C_IMODE];
  assign sw_config_lockout = cfg_c[`LCR_C_LOCK];
  assign soft_mode = (io_base_select == `LCR_IOB_SOFT);
  assign shared_mode = cfg_a[`LCR_A_MODE];

  // ------------------------------------------------------------
  // Host pin synchronisers
  // ------------------------------------------------------------
  // Stage one is read only by stage two
  reg [21:0] pin_s1;
  reg [21:0] pin_s2;
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      pin_s1 <= 22'h2c0000;
      pin_s2 <= 22'h2c0000;
    end
    else
    begin
      pin_s1 <= {1'b1, isa_bale, isa_ior_n, isa_iow_n, isa_sd, isa_sa};
      pin_s2 <= pin_s1;
    end
  end
  wire [9:0] sa_q;
  wire [7:0] sd_q;
  wire iow_q;
  wire ior_q;
  wire bale_q;
  assign sa_q = pin_s2[9:0];
  assign sd_q = pin_s2[17:10];
  assign iow_q = ~pin_s2[18];
  assign ior_q = ~pin_s2[19];
  assign bale_q = pin_s2[20];

  // ------------------------------------------------------------
  // Host cycle tracking and I/O decode
  // ------------------------------------------------------------
  reg iow_d;
  reg strobe_d;
  reg bale_seen;
  wire strobe_q;
  wire [9:0] io_base;
  wire io_hit;
  wire iow_start;
  wire strobe_end;
  assign strobe_q = iow_q | ior_q;
  assign io_base = `LCR_IO_ROOT + (`LCR_IO_STEP * {7'h00, io_base_select});
  // Sixteen-byte window; nothing answers in software mode
  assign io_hit = !soft_mode && (sa_q[9:4] == io_base[9:4]);
  assign iow_start = iow_q && !iow_d;
  assign strobe_end = strobe_d && !strobe_q;
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      iow_d <= 1'b0;
      strobe_d <= 1'b0;
      bale_seen <= 1'b0;
    end
    else
    begin
      iow_d <= iow_q;
      strobe_d <= strobe_q;
      // BALE marks the cycle until its strobe ends
      if (bale_q)
        bale_seen <= 1'b1;
      else if (strobe_end)
        bale_seen <= 1'b0;
    end
  end

  // Wait insertion point chosen by ready timing bit
  wire wait_window;
  wire want_wait;
  assign wait_window = cfg_b[`LCR_B_RDY] ? (bale_seen || strobe_q) : strobe_q;
  assign want_wait = io_hit && core_not_ready && wait_window;

  // ------------------------------------------------------------
  // Host-side outputs: wide I/O and ready
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      io16_n <= 1'b1;
      iochrdy_out <= 1'b0;
      iochrdy_oe_n <= 1'b1;
    end
    else
    begin
      // Decode answers early; strobe source suits slow decoders
      if (cfg_b[`LCR_B_IO16])
        io16_n <= !(io_hit && strobe_q);
      else
        io16_n <= !io_hit;
      // Open drain: pull ready low only while waiting
      iochrdy_oe_n <= !want_wait;
    end
  end

  // ------------------------------------------------------------
  // Software-mode load of the first register
  // ------------------------------------------------------------
  wire sw_load;
  wire [7:0] sw_load_data;
  lcr_sw_load u_sw_load
  (
    .mclk(mclk),
    .resetn(resetn),
    .armed(soft_mode),
    .wr_pulse(iow_start),
    .wr_addr(sa_q),
    .wr_data(sd_q),
    .load_pulse(sw_load),
    .load_data(sw_load_data)
  );

  // ------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then the answer
  // ------------------------------------------------------------
  wire bus_req;
  wire bus_commit;
  wire wr_commit;
  wire rd_commit;
  wire unlocked;
  reg [31:0] rd_mux;
  assign bus_req = avs_read || avs_write;
  assign bus_commit = bus_req && !avs_waitrequest;
  assign wr_commit = bus_commit && avs_write;
  assign rd_commit = bus_commit && avs_read;
  assign unlocked = !sw_config_lockout;

  // Read data view of the block state
  always @*
  begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `LCR_OFS_A:
        rd_mux = {24'h000000, cfg_a};
      `LCR_OFS_B:
        // Link bit reads back status, not the stored disable
        rd_mux = {24'h000000, cfg_b[7:6], bus_error_flag, cfg_b[4:3], link_good,
          cfg_b[1:0]};
      `LCR_OFS_C:
        rd_mux = {24'h000000, cfg_c};
      `LCR_OFS_RING:
        rd_mux = {rx_ring_page, ring_bound, ring_stop, ring_start};
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else if (bus_req && avs_waitrequest)
    begin
      // Answer next cycle; data held for the taking edge
      avs_waitrequest <= 1'b0;
      avs_readdata <= rd_mux;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      cfg_a <= `LCR_RST_A;
      cfg_b <= `LCR_RST_B;
      cfg_c <= `LCR_RST_C;
      ring_start <= `LCR_RST_RING_START;
      ring_stop <= `LCR_RST_RING_STOP;
      ring_bound <= `LCR_RST_RING_START;
    end
    else
    begin
      // Port load or an unlocked bus write leaves software mode; port load wins
      if (sw_load)
        cfg_a <= sw_load_data;
      else if (wr_commit && unlocked && avs_address == `LCR_OFS_A)
        cfg_a <= avs_writedata[7:0];
      if (wr_commit && unlocked && avs_address == `LCR_OFS_B)
        cfg_b <= avs_writedata[7:0];
      // Third register stays writable so lockout can be lifted
      if (wr_commit && avs_address == `LCR_OFS_C)
        cfg_c <= avs_writedata[7:0];
      if (wr_commit && avs_address == `LCR_OFS_RING)
      begin
        ring_start <= avs_writedata[7:0];
        ring_stop <= avs_writedata[15:8];
        ring_bound <= avs_writedata[23:16];
      end
    end
  end

  // ------------------------------------------------------------
  // Bus error: host ended a cycle we were stretching
  // ------------------------------------------------------------
  reg waiting_d;
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      waiting_d <= 1'b0;
      bus_error_flag <= 1'b0;
    end
    else
    begin
      waiting_d <= want_wait;
      // Set wins over the read that clears it
      if (strobe_end && waiting_d)
        bus_error_flag <= 1'b1;
      else if (rd_commit && avs_address == `LCR_OFS_B)
        bus_error_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Configuration outputs
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      fast_remote_read_en <= 1'b0;
      host_bus_mode_sel <= 1'b0;
      medium_select <= 2'h0;
      thin_enable <= 1'b0;
      link_test_disable <= 1'b0;
      boot_rom_enable <= 1'b0;
      boot_rom_window_sel <= 4'h0;
      boot_rom_write_allow <= 1'b0;
      eeprom_store_enable <= 1'b0;
      ram_full_depth <= 1'b0;
      core_clock_source_sel <= 1'b0;
    end
    else
    begin
      fast_remote_read_en <= cfg_a[`LCR_A_FAST_REMOTE_READ_EN];
      host_bus_mode_sel <= shared_mode;
      medium_select <= cfg_b[`LCR_B_MED_HI:`LCR_B_MED_LO];
      // Converter power only for thin coax
      thin_enable <= (cfg_b[`LCR_B_MED_HI:`LCR_B_MED_LO] == `LCR_MED_THIN);
      link_test_disable <= cfg_b[`LCR_B_LINK];
      boot_rom_window_sel <= cfg_c[`LCR_C_BPS_HI:`LCR_C_BPS_LO];
      boot_rom_enable <= (cfg_c[`LCR_C_BPS_HI:1] != 3'h0);
      // No write cycles to a disabled boot window either
      boot_rom_write_allow <= cfg_b[`LCR_B_BOOT_ROM_WRITE_ALLOW] && (cfg_c[`LCR_C_BPS_HI:1] != 3'h0);
      eeprom_store_enable <= cfg_b[`LCR_B_EEST];
      ram_full_depth <= cfg_c[`LCR_C_DEPTH];
      core_clock_source_sel <= cfg_c[`LCR_C_CLKS];
    end
  end

  // ------------------------------------------------------------
  // Interrupt pins: direct line or coded strobe
  // ------------------------------------------------------------
  reg [7:0] irq_onehot;
  always @*
  begin
    irq_onehot = 8'h00;
    irq_onehot[irq_line_select] = 1'b1;
  end
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      irq_direct <= 8'h00;
      irq_code <= 3'h0;
      irq_strobe_out <= 1'b0;
    end
    else if (irq_encoding_sel)
    begin
      // Code pins are static; strobe follows the event
      irq_direct <= 8'h00;
      irq_code <= irq_line_select;
      irq_strobe_out <= core_irq;
    end
    else
    begin
      irq_direct <= core_irq ? irq_onehot : 8'h00;
      irq_code <= 3'h0;
      irq_strobe_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Buffer RAM ownership
  // ------------------------------------------------------------
  // Host memory path exists only in shared mode, latch path in port mode
  wire arb_host_req;
  wire arb_core;
  wire arb_host;
  assign arb_host_req = shared_mode ? host_mem_req : host_latch_req;
  lcr_ram_arb u_ram_arb
  (
    .mclk(mclk),
    .resetn(resetn),
    .core_req(core_dma_burst),
    .host_req(arb_host_req),
    .core_grant(arb_core),
    .host_grant(arb_host)
  );
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      core_ram_grant <= 1'b0;
      host_ram_grant <= 1'b0;
      ram_host_addr <= 16'h0000;
    end
    else
    begin
      core_ram_grant <= arb_core;
      host_ram_grant <= arb_host;
      // Compatible map wraps host addresses at 16 kbytes
      ram_host_addr <= ram_full_depth ? host_ram_addr : {2'h0, host_ram_addr[13:0]};
    end
  end

  // ------------------------------------------------------------
  // Receive ring page pointer
  // ------------------------------------------------------------
  // Full when the next page would overrun unread data
  wire [7:0] page_inc;
  wire [7:0] page_next;
  assign page_inc = rx_ring_page + 8'h01;
  assign page_next = (page_inc >= ring_stop) ? ring_start : page_inc;
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      rx_ring_page <= `LCR_RST_RING_START;
      rx_ring_full <= 1'b0;
    end
    else
    begin
      if (wr_commit && avs_address == `LCR_OFS_RING)
        rx_ring_page <= avs_writedata[7:0];
      else if (rx_page_done && !rx_ring_full)
        rx_ring_page <= page_next;
      rx_ring_full <= (page_next == ring_bound);
    end
  end
endmodule

// >>> sim/lcr_isa_host.sv
// Host bus model that runs single byte cycles on the slot pins
`timescale 1ns/100ps
module lcr_isa_host
(
  input wire mclk,
  input wire start,
  input wire wr,
  input wire [9:0] addr,
  input wire [7:0] data,
  output reg [9:0] isa_sa,
  output reg [7:0] isa_sd,
  output reg isa_iow_n,
  output reg isa_ior_n,
  output reg isa_bale,
  output reg busy
);
  // Cycle phase counter
  reg [3:0] cnt;
  initial
  begin
    isa_sa = 10'h0;
    isa_sd = 8'h0;
    isa_iow_n = 1'b1;
    isa_ior_n = 1'b1;
    isa_bale = 1'b0;
    busy = 1'b0;
    cnt = 4'h0;
  end
  // ------------------------------------------------------------
  // One cycle: latch pulse, ten strobe cycles, then release
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    isa_bale <= start;
    if (start)
    begin
      // Address and data held for the whole cycle
      isa_sa <= addr;
      isa_sd <= data;
      busy <= 1'b1;
      cnt <= 4'h0;
    end
    else if (busy)
    begin
      cnt <= cnt + 4'h1;
      isa_iow_n <= !(wr && cnt < 4'ha);
      isa_ior_n <= !(!wr && cnt < 4'ha);
      if (cnt == 4'hc)
      begin
        // Released lines must not keep the old value
        busy <= 1'b0;
        isa_sa <= ~isa_sa;
        isa_sd <= ~isa_sd;
      end
    end
  end
endmodule

// >>> sim/lcr_config_regs_monitor.sv
// Concurrent checks on the configuration block outputs
`timescale 1ns/100ps
module lcr_chk_monitor
(
  input wire mclk,
  input wire resetn,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire core_irq,
  input wire [7:0] irq_direct,
  input wire [2:0] irq_code,
  input wire irq_strobe_out,
  input wire [1:0] medium_select,
  input wire thin_enable,
  input wire boot_rom_enable,
  input wire [3:0] boot_rom_window_sel,
  input wire boot_rom_write_allow,
  input wire ram_full_depth,
  input wire [15:0] ram_host_addr,
  input wire core_dma_burst,
  input wire core_ram_grant,
  input wire host_ram_grant
);
  // ------------------------------------------------------------
  // Single clock domain
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  thin_enc_a: assert property (thin_enable == (medium_select == 2'h1))
    else $error("thin enable does not match medium code");
  boot_off_a: assert property (boot_rom_enable == (boot_rom_window_sel[3:1] != 3'h0))
    else $error("boot enable does not match window field");
  boot_wr_a: assert property (boot_rom_write_allow |-> boot_rom_enable)
    else $error("boot write allowed while boot disabled");
  irq_modes_a: assert property ((irq_direct != 8'h0) |-> (irq_code == 3'h0 && !irq_strobe_out))
    else $error("direct and coded interrupt outputs both active");
  irq_onehot_a: assert property ((irq_direct != 8'h0) |-> $onehot(irq_direct))
    else $error("more than one direct interrupt line");
  strobe_src_a: assert property ($rose(irq_strobe_out) |-> $past(core_irq))
    else $error("interrupt strobe without core interrupt");
  depth_map_a: assert property (!ram_full_depth |-> ram_host_addr[15:14] == 2'h0)
    else $error("upper address bits pass in small map");
  grant_excl_a: assert property (!(core_ram_grant && host_ram_grant))
    else $error("both RAM grants high");
  core_burst_a: assert property (core_ram_grant |-> $past(core_dma_burst, 2))
    else $error("core grant without burst request");
  core_wins_a: assert property ($rose(host_ram_grant) |-> !$past(core_dma_burst, 2))
    else $error("host granted over requesting core");
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  cover property (core_ram_grant);
  cover property (host_ram_grant);
  cover property (irq_strobe_out);
endmodule
bind lcr_config_regs lcr_chk_monitor u_chk (.mclk, .resetn, .avs_read, .avs_write,
  .avs_waitrequest, .core_irq, .irq_direct, .irq_code, .irq_strobe_out, .medium_select,
  .thin_enable, .boot_rom_enable, .boot_rom_window_sel, .boot_rom_write_allow,
  .ram_full_depth, .ram_host_addr, .core_dma_burst, .core_ram_grant, .host_ram_grant);

// >>> sim/test_lan_controller_config_regs.sv
// Self-checking bench for the configuration register block
`timescale 1ns/100ps
`include "lcr_defs.vh"
module test_lan_controller_config_regs;
  // ------------------------------------------------------------
  // Stimulus, design outputs and scoreboard
  // ------------------------------------------------------------
  reg mclk = 1'b0;
  reg resetn = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg core_not_ready = 1'b0, link_good = 1'b0, core_irq = 1'b0, core_dma_burst = 1'b0;
  reg host_mem_req = 1'b0, rx_page_done = 1'b0, isa_go = 1'b0;
  reg [15:0] host_ram_addr = 16'h0;
  reg [9:0] isa_addr = 10'h0;
  reg [7:0] isa_data = 8'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, io16_n, iochrdy_out, iochrdy_oe_n, isa_busy;
  wire isa_iow_n, isa_ior_n, isa_bale, irq_strobe_out, thin_enable, link_test_disable;
  wire fast_remote_read_en, host_bus_mode_sel, boot_rom_enable, boot_rom_write_allow;
  wire eeprom_store_enable, ram_full_depth, core_clock_source_sel, rx_ring_full;
  wire core_ram_grant, host_ram_grant;
  wire [9:0] isa_sa;
  wire [7:0] isa_sd, irq_direct, rx_ring_page;
  wire [2:0] irq_code;
  wire [1:0] medium_select;
  wire [3:0] boot_rom_window_sel;
  wire [15:0] ram_host_addr;
  integer n_errors = 0, compares = 0, i;
  logic [31:0] exp_q [$];
  reg [7:0] va, vb, vc;
  reg [2:0] irq;
  // Latch data path is not modelled, so its request stays low
  lcr_config_regs uut (.mclk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .isa_sa, .isa_sd, .isa_iow_n,
    .isa_ior_n, .isa_bale, .io16_n, .iochrdy_out, .iochrdy_oe_n, .core_not_ready,
    .link_good, .core_irq, .irq_direct, .irq_code, .irq_strobe_out, .fast_remote_read_en,
    .host_bus_mode_sel, .thin_enable, .medium_select, .link_test_disable, .boot_rom_enable,
    .boot_rom_window_sel, .boot_rom_write_allow, .eeprom_store_enable, .ram_full_depth,
    .core_clock_source_sel, .core_dma_burst, .host_mem_req, .host_latch_req(1'b0),
    .host_ram_addr, .ram_host_addr, .core_ram_grant, .host_ram_grant, .rx_page_done,
    .rx_ring_page, .rx_ring_full);
  lcr_isa_host host (.mclk, .start(isa_go), .wr(1'b1), .addr(isa_addr), .data(isa_data),
    .isa_sa, .isa_sd, .isa_iow_n, .isa_ior_n, .isa_bale, .busy(isa_busy));
  always #2.5 mclk = ~mclk;
  task finish_test;
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask
  // Reads of the second register carry the live link pin in bit 2
  function [31:0] bexp(input [7:0] v);
    bexp = {24'h0, v[7:3], link_good, v[1:0]};
  endfunction
  // Avalon transfer: request held until waitrequest is seen low
  task bus(input [3:0] a, input rd, input [31:0] d);
    integer k;
    @(posedge mclk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    for (k = 0; k < 20 && avs_waitrequest !== 1'b0; k++)
      @(posedge mclk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k == 20)
    begin
      n_errors++;
      finish_test;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b1, 32'h0);
  endtask
  task wr(input [3:0] a, input [7:0] d);
    bus(a, 1'b0, {24'h0, d});
  endtask
  // Host write cycle; ready and width pins looked at in mid-strobe
  task isa(input [9:0] a, input [7:0] d, input [1:0] e);
    integer k;
    @(posedge mclk);
    isa_addr <= a;
    isa_data <= d;
    isa_go <= 1'b1;
    @(posedge mclk);
    isa_go <= 1'b0;
    repeat (6) @(posedge mclk);
    check("io16_oe", {iochrdy_out, io16_n, iochrdy_oe_n}, {1'b0, e});
    for (k = 0; k < 40 && isa_busy !== 1'b0; k++)
      @(posedge mclk);
    if (k == 40)
    begin
      n_errors++;
      finish_test;
    end
    repeat (4) @(posedge mclk);
  endtask
  // Read answers are matched against the oldest noted value
  always @(posedge mclk)
    if (avs_read && avs_waitrequest === 1'b0)
      check("readdata", avs_readdata, exp_q.size() ? exp_q.pop_front() : 32'hx);
  initial
  begin
    void'($urandom(32'h8000c64b));
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    rd(`LCR_OFS_A, `LCR_RST_A);
    rd(`LCR_OFS_B, `LCR_RST_B);
    rd(`LCR_OFS_C, `LCR_RST_C);
    rd(`LCR_OFS_RING, {8'h46, 8'h46, `LCR_RST_RING_STOP, `LCR_RST_RING_START});
    wr(4'h1, 8'hff);
    rd(4'h1, 32'h0);
    irq = $urandom;
    va = {2'b11, irq, 3'h2};
    isa(10'h220, va, 2'b11);
    // Host sequence: three port writes, a stray write, three more
    for (i = 0; i < 7; i++)
      isa(i == 3 ? 10'h300 : `LCR_SW_PORT, va, 2'b11);
    rd(`LCR_OFS_A, `LCR_RST_A);
    isa(`LCR_SW_PORT, va, 2'b11);
    rd(`LCR_OFS_A, va);
    check("mode", {fast_remote_read_en, host_bus_mode_sel}, 2'b11);
    for (i = 0; i < 4; i++)
    begin
      vb = $urandom;
      vb[5] = 1'b0;
      vb[1:0] = i;
      link_good <= $urandom;
      wr(`LCR_OFS_B, vb);
      repeat (2) @(posedge mclk);
      check("media", {medium_select, thin_enable, link_test_disable, eeprom_store_enable},
        {vb[1:0], i == 1, vb[2], vb[7]});
      rd(`LCR_OFS_B, bexp(vb));
    end
    wr(`LCR_OFS_B, 8'h41);
    for (i = 0; i < 4; i++)
    begin
      vc = i == 0 ? 8'h01 : (i == 1 ? 8'h5e : 8'($urandom) & 8'h7f);
      wr(`LCR_OFS_C, vc);
      repeat (2) @(posedge mclk);
      check("boot", {boot_rom_enable, boot_rom_write_allow, ram_full_depth,
        core_clock_source_sel, boot_rom_window_sel},
        {vc[3:1] != 3'h0, vc[3:1] != 3'h0, vc[4], vc[6], vc[3:0]});
      rd(`LCR_OFS_C, vc);
    end
    wr(`LCR_OFS_C, 8'h80);
    wr(`LCR_OFS_A, 8'h00);
    wr(`LCR_OFS_B, 8'h00);
    rd(`LCR_OFS_A, va);
    rd(`LCR_OFS_B, bexp(8'h41));
    wr(`LCR_OFS_C, 8'h00);
    wr(`LCR_OFS_B, 8'h40);
    rd(`LCR_OFS_B, bexp(8'h40));
    core_irq <= 1'b1;
    repeat (3) @(posedge mclk);
    check("direct", {irq_direct, irq_code, irq_strobe_out}, {8'h01 << irq, 4'h0});
    wr(`LCR_OFS_C, 8'h20);
    repeat (3) @(posedge mclk);
    check("coded", {irq_direct, irq_code, irq_strobe_out}, {8'h0, irq, 1'b1});
    core_irq <= 1'b0;
    // Both parties ask in the same cycle
    core_dma_burst <= 1'b1;
    host_mem_req <= 1'b1;
    host_ram_addr <= 16'hffff;
    repeat (4) @(posedge mclk);
    check("core_win", {core_ram_grant, host_ram_grant, ram_host_addr}, 18'h23fff);
    core_dma_burst <= 1'b0;
    repeat (4) @(posedge mclk);
    check("host_win", {core_ram_grant, host_ram_grant}, 2'b01);
    host_mem_req <= 1'b0;
    // Wait requested, host ends the strobe anyway
    core_not_ready <= 1'b1;
    isa(10'h241, 8'h00, 2'b00);
    core_not_ready <= 1'b0;
    rd(`LCR_OFS_B, bexp(8'h60));
    rd(`LCR_OFS_B, bexp(8'h40));
    rx_page_done <= 1'b1;
    @(posedge mclk);
    rx_page_done <= 1'b0;
    repeat (2) @(posedge mclk);
    check("page", {rx_ring_full, rx_ring_page}, 9'h047);
    rd(`LCR_OFS_RING, 32'h47468046);
    finish_test;
  end
endmodule
